//--- src/tdp_map.svh
`ifndef TDP_MAP_SVH
`define TDP_MAP_SVH
`define TDP_OFS_CTRL_A    8'h00
`define TDP_OFS_CTRL_B    8'h04
`define TDP_OFS_COUNT     8'h08
`define TDP_OFS_CMP_A     8'h0C
`define TDP_OFS_CMP_B     8'h10
`define TDP_OFS_CAPTURE   8'h14
`define TDP_OFS_FLAGS     8'h18
`define TDP_OFS_PINS      8'h1C
`define TDP_CA_MODE_A_HI  7
`define TDP_CA_MODE_A_LO  6
`define TDP_CA_MODE_B_HI  5
`define TDP_CA_MODE_B_LO  4
`define TDP_CA_FORCE_A    3
`define TDP_CA_FORCE_B    2
`define TDP_CB_WGM_HI     4
`define TDP_CB_WGM_LO     3
`define TDP_CTRL_A_RST    8'h00
`define TDP_CTRL_B_RST    8'h00
`define TDP_BOTTOM        16'h0000
`define TDP_MAX           16'hFFFF
`define TDP_DIV_8         10'h007
`define TDP_DIV_64        10'h03F
`define TDP_DIV_256       10'h0FF
`define TDP_DIV_1024      10'h3FF
`endif

//--- src/tdp_pkg.sv
package tdp_pkg;
  typedef enum logic [1:0] {TDP_NON_PWM, TDP_FAST, TDP_DUAL_TOP, TDP_DUAL_BOT} tdp_class_t;
  typedef struct packed {
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic        hsel;
  } tdp_ahb_req_t;
  typedef struct packed {
    logic [15:0] top;
    logic        tick;
    logic        at_top;
    logic        at_bot;
  } tdp_cnt_t;
endpackage

//--- src/tdp_timer.sv
`timescale 1ns/100ps
`include "tdp_map.svh"
module tdp_timer
  import tdp_pkg::*;
(
  input  wire logic         ref_clk_in,
  input  wire logic         rst_b_in,
  input  wire tdp_ahb_req_t ahb_req_in,
  input  wire logic         hready_in,
  input  wire logic [31:0]  hwdata_in,
  output logic [31:0]       hrdata_out,
  output logic              hreadyout_out,
  output logic              hresp_out,
  input  wire logic         port_data_a_in,
  input  wire logic         port_data_b_in,
  output logic              pad_a_out,
  output logic              pad_a_oe_out,
  output logic              pad_b_out,
  output logic              pad_b_oe_out
);

  logic [7:0]  ctrl_a_q;
  logic [7:0]  ctrl_b_q;
  logic [15:0] count_q;
  logic [15:0] cmp_buf_a_q;
  logic [15:0] cmp_buf_b_q;
  logic [15:0] cmp_a_q;
  logic [15:0] cmp_b_q;
  logic [15:0] capture_q;
  logic        down_q;
  logic        ovf_flag_q;
  logic        cap_flag_q;
  logic [1:0]  match_flag_q;
  logic [1:0]  wave_q;
  logic [1:0]  dir_q;
  logic [9:0]  pre_q;
  logic        wr_pend_q;
  logic [7:0]  wr_addr_q;
  logic [7:0]  rd_addr;
  logic [3:0]  wgm;
  tdp_class_t  cls;
  tdp_cnt_t    cnt;
  logic        wr_en;
  logic        rd_en;
  logic        tick_c;
  logic [1:0]  force_s;
  logic [1:0]  match;
  logic [15:0] cmp_v [2];
  logic [1:0]  omode [2];

  // Mode bits 3:2 live in control register B
  assign wgm = {ctrl_b_q[`TDP_CB_WGM_HI:`TDP_CB_WGM_LO], ctrl_a_q[1:0]};

  function automatic tdp_class_t mode_class(input logic [3:0] m);
    case (m)
      4'h0, 4'h4, 4'hC, 4'hD: mode_class = TDP_NON_PWM;
      4'h5, 4'h6, 4'h7, 4'hE, 4'hF: mode_class = TDP_FAST;
      4'h8, 4'h9: mode_class = TDP_DUAL_BOT;
      default: mode_class = TDP_DUAL_TOP;
    endcase
  endfunction

  function automatic logic [15:0] top_of(input logic [3:0] m, input logic [15:0] icr,
                                         input logic [15:0] oca);
    case (m)
      4'h1, 4'h5: top_of = 16'h00FF;
      4'h2, 4'h6: top_of = 16'h01FF;
      4'h3, 4'h7: top_of = 16'h03FF;
      4'h8, 4'hA, 4'hC, 4'hE: top_of = icr;
      4'h4, 4'h9, 4'hB, 4'hF: top_of = oca;
      default: top_of = `TDP_MAX;
    endcase
  endfunction

  function automatic logic is_reg(input logic [7:0] a, input logic [7:0] ofs);
    is_reg = (a == ofs);
  endfunction

  // Toggle mode reaches a pin only where that toggle is defined for it
  function automatic logic wave_on(input logic chan_b, input logic [1:0] om,
                                   input tdp_class_t c, input logic [3:0] m);
    if (om == 2'b00) begin
      wave_on = 1'b0;
    end else if (om != 2'b01 || c == TDP_NON_PWM) begin
      wave_on = 1'b1;
    end else begin
      wave_on = !chan_b && ((c == TDP_FAST) ? (m == 4'hF) : (m == 4'h9 || m == 4'hE));
    end
  endfunction

  assign cls = mode_class(wgm);
  assign cnt.top = top_of(wgm, capture_q, cmp_a_q);
  assign cnt.at_top = (count_q == cnt.top);
  assign cnt.at_bot = (count_q == `TDP_BOTTOM);

  // Prescaled tick qualifies the single system clock
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      pre_q <= 10'h000;
    end else begin
      pre_q <= pre_q + 10'h001;
    end
  end

  always_comb begin
    case (ctrl_b_q[2:0])
      3'h1: tick_c = 1'b1;
      3'h2: tick_c = ((pre_q & `TDP_DIV_8) == 10'h000);
      3'h3: tick_c = ((pre_q & `TDP_DIV_64) == 10'h000);
      3'h4: tick_c = ((pre_q & `TDP_DIV_256) == 10'h000);
      3'h5: tick_c = (pre_q == 10'h000);
      default: tick_c = 1'b0;
    endcase
  end

  // Kept apart from the struct so one process does not share it with assigns
  assign cnt.tick = tick_c;

  // AHB-Lite slave, zero wait states
  assign wr_en = ahb_req_in.hsel && hready_in && ahb_req_in.htrans[1] && ahb_req_in.hwrite;
  assign rd_en = ahb_req_in.hsel && hready_in && ahb_req_in.htrans[1] && !ahb_req_in.hwrite;
  assign rd_addr = ahb_req_in.haddr[7:0];
  assign hreadyout_out = 1'b1;
  assign hresp_out = 1'b0;

  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
    end else begin
      wr_pend_q <= wr_en;
      wr_addr_q <= ahb_req_in.haddr[7:0];
    end
  end

  // Unmapped addresses read zero; force strobes never read back
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      hrdata_out <= 32'h0000_0000;
    end else if (rd_en) begin
      hrdata_out <= 32'h0000_0000;
      if (is_reg(rd_addr, `TDP_OFS_CTRL_A)) hrdata_out[7:0] <= ctrl_a_q;
      if (is_reg(rd_addr, `TDP_OFS_CTRL_B)) hrdata_out[7:0] <= ctrl_b_q;
      if (is_reg(rd_addr, `TDP_OFS_COUNT)) hrdata_out[15:0] <= count_q;
      if (is_reg(rd_addr, `TDP_OFS_CMP_A)) hrdata_out[15:0] <= cmp_buf_a_q;
      if (is_reg(rd_addr, `TDP_OFS_CMP_B)) hrdata_out[15:0] <= cmp_buf_b_q;
      if (is_reg(rd_addr, `TDP_OFS_CAPTURE)) hrdata_out[15:0] <= capture_q;
      if (is_reg(rd_addr, `TDP_OFS_FLAGS)) begin
        hrdata_out[4:0] <= {down_q, cap_flag_q, match_flag_q, ovf_flag_q};
      end
      if (is_reg(rd_addr, `TDP_OFS_PINS)) hrdata_out[3:0] <= {dir_q, wave_q};
    end
  end

  // Strobes are not stored, so a read of bits 3:2 gives zero
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ctrl_a_q <= `TDP_CTRL_A_RST;
      ctrl_b_q <= `TDP_CTRL_B_RST;
      capture_q <= 16'h0000;
      dir_q <= 2'b00;
    end else if (wr_pend_q) begin
      if (is_reg(wr_addr_q, `TDP_OFS_CTRL_A)) begin
        ctrl_a_q <= {hwdata_in[7:4], 2'b00, hwdata_in[1:0]};
      end
      if (is_reg(wr_addr_q, `TDP_OFS_CTRL_B)) ctrl_b_q <= {3'b000, hwdata_in[4:0]};
      if (is_reg(wr_addr_q, `TDP_OFS_CAPTURE)) capture_q <= hwdata_in[15:0];
      if (is_reg(wr_addr_q, `TDP_OFS_PINS)) dir_q <= hwdata_in[3:2];
    end
  end

  // Forced match only acts in non-PWM modes
  assign force_s[0] = wr_pend_q && is_reg(wr_addr_q, `TDP_OFS_CTRL_A)
                      && hwdata_in[`TDP_CA_FORCE_A] && (cls == TDP_NON_PWM);
  assign force_s[1] = wr_pend_q && is_reg(wr_addr_q, `TDP_OFS_CTRL_A)
                      && hwdata_in[`TDP_CA_FORCE_B] && (cls == TDP_NON_PWM);

  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      cmp_buf_a_q <= 16'h0000;
      cmp_buf_b_q <= 16'h0000;
    end else if (wr_pend_q) begin
      if (is_reg(wr_addr_q, `TDP_OFS_CMP_A)) cmp_buf_a_q <= hwdata_in[15:0];
      if (is_reg(wr_addr_q, `TDP_OFS_CMP_B)) cmp_buf_b_q <= hwdata_in[15:0];
    end
  end

  // Active compare update point depends on mode class
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      cmp_a_q <= 16'h0000;
      cmp_b_q <= 16'h0000;
    end else if (cls == TDP_NON_PWM) begin
      cmp_a_q <= cmp_buf_a_q;
      cmp_b_q <= cmp_buf_b_q;
    end else if (cnt.tick && (((cls == TDP_DUAL_BOT) && cnt.at_bot)
                 || ((cls == TDP_DUAL_TOP) && cnt.at_top)
                 || ((cls == TDP_FAST) && cnt.at_bot))) begin
      cmp_a_q <= cmp_buf_a_q;
      cmp_b_q <= cmp_buf_b_q;
    end
  end

  // Counter and direction; turning on TOP lets every value stand one tick,
  // so a dual-slope period is exactly twice TOP
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      count_q <= `TDP_BOTTOM;
      down_q <= 1'b0;
    end else if (wr_pend_q && is_reg(wr_addr_q, `TDP_OFS_COUNT)) begin
      count_q <= hwdata_in[15:0];
    end else if (cnt.tick) begin
      if (cls == TDP_DUAL_TOP || cls == TDP_DUAL_BOT) begin
        if (!down_q && cnt.at_top && !cnt.at_bot) begin
          down_q <= 1'b1;
          count_q <= count_q - 16'h0001;
        end else if (down_q && !cnt.at_bot) begin
          count_q <= count_q - 16'h0001;
        end else begin
          // A TOP of zero must not wrap the count below BOTTOM
          down_q <= 1'b0;
          count_q <= count_q + 16'h0001;
        end
      end else begin
        down_q <= 1'b0;
        if (cnt.at_top && wgm != 4'h0) count_q <= `TDP_BOTTOM;
        else count_q <= count_q + 16'h0001;
      end
    end
  end

  // Compare above TOP never equals count, so no match then
  assign cmp_v[0] = cmp_a_q;
  assign cmp_v[1] = cmp_b_q;
  assign omode[0] = ctrl_a_q[`TDP_CA_MODE_A_HI:`TDP_CA_MODE_A_LO];
  assign omode[1] = ctrl_a_q[`TDP_CA_MODE_B_HI:`TDP_CA_MODE_B_LO];

  // Flags: writing one clears, hardware set wins over clear
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ovf_flag_q <= 1'b0;
      cap_flag_q <= 1'b0;
    end else begin
      // Same tick as the BOTTOM compare load in modes 8 and 9; the other dual-slope modes load at TOP
      if (cnt.tick && cnt.at_bot && (cls == TDP_DUAL_BOT || cls == TDP_DUAL_TOP)) begin
        ovf_flag_q <= 1'b1;
      end else if (cnt.tick && cnt.at_top && cls == TDP_FAST) begin
        ovf_flag_q <= 1'b1;
      end else if (cnt.tick && count_q == `TDP_MAX && cls == TDP_NON_PWM) begin
        ovf_flag_q <= 1'b1;
      end else if (wr_pend_q && is_reg(wr_addr_q, `TDP_OFS_FLAGS) && hwdata_in[0]) begin
        ovf_flag_q <= 1'b0;
      end
      if (cnt.tick && cnt.at_top && (wgm == 4'h8 || wgm == 4'hA || wgm == 4'hE)) begin
        cap_flag_q <= 1'b1;
      end else if (wr_pend_q && is_reg(wr_addr_q, `TDP_OFS_FLAGS) && hwdata_in[3]) begin
        cap_flag_q <= 1'b0;
      end
    end
  end

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_chan
      logic act;
      logic ovr;
      assign match[g] = cnt.tick && (count_q == cmp_v[g]);
      // A compare sitting on TOP is served by the TOP action instead
      assign ovr = (cmp_v[g] == cnt.top);
      // Top-defining compare A matches at TOP, giving its flag there
      always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
          match_flag_q[g] <= 1'b0;
        end else if (match[g]) begin
          match_flag_q[g] <= 1'b1;
        end else if (wr_pend_q && is_reg(wr_addr_q, `TDP_OFS_FLAGS) && hwdata_in[g+1]) begin
          match_flag_q[g] <= 1'b0;
        end
      end

      // Waveform decode per mode class
      assign act = match[g] || force_s[g];
      always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
          wave_q[g] <= 1'b0;
        end else begin
          case (cls)
            TDP_NON_PWM: begin
              if (act) begin
                case (omode[g])
                  2'b01: wave_q[g] <= ~wave_q[g];
                  2'b10: wave_q[g] <= 1'b0;
                  2'b11: wave_q[g] <= 1'b1;
                  default: wave_q[g] <= wave_q[g];
                endcase
              end
            end
            TDP_FAST: begin
              if (omode[g] == 2'b01) begin
                if (g == 0 && wgm == 4'hF && match[g]) wave_q[g] <= ~wave_q[g];
              end else if (omode[g][1] && cnt.tick && cnt.at_top) begin
                wave_q[g] <= ~omode[g][0];
              end else if (omode[g][1] && match[g] && !ovr) begin
                wave_q[g] <= omode[g][0];
              end
            end
            default: begin
              if (omode[g] == 2'b01) begin
                if (g == 0 && (wgm == 4'h9 || wgm == 4'hE) && match[g]) begin
                  wave_q[g] <= ~wave_q[g];
                end
              end else if (omode[g][1] && match[g]) begin
                // Turning point match keeps steady level at BOTTOM/TOP
                if (cnt.at_top) wave_q[g] <= ~omode[g][0];
                else if (cnt.at_bot) wave_q[g] <= omode[g][0];
                else if (!down_q) wave_q[g] <= omode[g][0];
                else wave_q[g] <= ~omode[g][0];
              end
            end
          endcase
        end
      end
    end
  endgenerate

  // Pin mux: waveform overrides port data, driver gated by direction
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      pad_a_out <= 1'b0;
      pad_b_out <= 1'b0;
    end else begin
      pad_a_out <= wave_on(1'b0, omode[0], cls, wgm) ? wave_q[0] : port_data_a_in;
      pad_b_out <= wave_on(1'b1, omode[1], cls, wgm) ? wave_q[1] : port_data_b_in;
    end
  end

  assign pad_a_oe_out = dir_q[0];
  assign pad_b_oe_out = dir_q[1];

endmodule // tdp_timer

//--- sim/tdp_timer_chk.sv
`timescale 1ns/100ps
`include "tdp_map.svh"
module tdp_timer_chk
  import tdp_pkg::*;
(
  input  wire logic         ref_clk_in,
  input  wire logic         rst_b_in,
  input  wire tdp_ahb_req_t ahb_req_in,
  input  wire logic         hready_in,
  input  wire logic [31:0]  hwdata_in,
  input  wire logic [31:0]  hrdata_out,
  input  wire logic         hreadyout_out,
  input  wire logic         hresp_out,
  input  wire logic         pad_a_out,
  input  wire logic         pad_a_oe_out,
  input  wire logic         pad_b_out,
  input  wire logic         pad_b_oe_out
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!rst_b_in);
  logic       acc, wr_q, rd_q, cawr_q, stop;
  logic [7:0] ad_q, ca_q, cb_q;
  logic [2:0] quiet_q, pins_q;
  assign acc  = ahb_req_in.hsel & hready_in & ahb_req_in.htrans[1];
  assign stop = (cb_q[2:0] == 3'h0) || (cb_q[2:0] > 3'h5);
  // Shadow copies let the checks follow what software configured
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      {wr_q, rd_q, cawr_q} <= 3'h0;
      {ad_q, ca_q, cb_q}   <= 24'h0;
      {quiet_q, pins_q}    <= 6'h0;
    end else begin
      wr_q    <= acc & ahb_req_in.hwrite;
      rd_q    <= acc & ~ahb_req_in.hwrite;
      ad_q    <= ahb_req_in.haddr[7:0];
      cawr_q  <= cawr_q | (acc & ahb_req_in.hwrite & (ahb_req_in.haddr[7:0] == `TDP_OFS_CTRL_A));
      quiet_q <= acc ? 3'h5 : quiet_q - 3'(quiet_q != 3'h0);
      pins_q  <= (acc && ahb_req_in.haddr[7:0] == `TDP_OFS_PINS) ? 3'h5
                 : pins_q - 3'(pins_q != 3'h0);
      if (wr_q && ad_q == `TDP_OFS_CTRL_A) ca_q <= hwdata_in[7:0];
      if (wr_q && ad_q == `TDP_OFS_CTRL_B) cb_q <= hwdata_in[7:0];
    end
  end
  property p_okay; hresp_out == 1'b0 && hreadyout_out == 1'b1; endproperty
  a_okay: assert property (p_okay) else $error("bus answer not zero-wait OKAY");
  property p_ca_rd; rd_q && ad_q == `TDP_OFS_CTRL_A |-> hrdata_out == {24'h0, ca_q & 8'hF3}; endproperty
  a_ca_rd: assert property (p_ca_rd) else $error("control A readback wrong");
  property p_rst_val; rd_q && ad_q == `TDP_OFS_CTRL_A && !cawr_q |-> hrdata_out == 32'h0; endproperty
  a_rst_val: assert property (p_rst_val) else $error("control A reset value wrong");
  property p_unmapped; rd_q && ad_q >= 8'h20 |-> hrdata_out == 32'h0; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_oe_a; $changed(pad_a_oe_out) |-> pins_q != 3'h0; endproperty
  a_oe_a: assert property (p_oe_a) else $error("pad A enable moved without write");
  property p_oe_b; $changed(pad_b_oe_out) |-> pins_q != 3'h0; endproperty
  a_oe_b: assert property (p_oe_b) else $error("pad B enable moved without write");
  property p_quiet_a; quiet_q == 3'h0 && stop && ca_q[7:6] != 2'h0 |=> $stable(pad_a_out);
  endproperty
  a_quiet_a: assert property (p_quiet_a) else $error("pad A moved with no tick");
  property p_quiet_b; quiet_q == 3'h0 && stop && ca_q[5:4] != 2'h0 |=> $stable(pad_b_out);
  endproperty
  a_quiet_b: assert property (p_quiet_b) else $error("pad B moved with no tick");
  c_ca_rd: cover property (rd_q && ad_q == `TDP_OFS_CTRL_A);
  c_rise_a: cover property ($rose(pad_a_out));
  c_oe_b: cover property ($changed(pad_b_oe_out));
endmodule // tdp_timer_chk

bind tdp_timer tdp_timer_chk u_chk (
  .ref_clk_in(ref_clk_in), .rst_b_in(rst_b_in), .ahb_req_in(ahb_req_in),
  .hready_in(hready_in), .hwdata_in(hwdata_in), .hrdata_out(hrdata_out),
  .hreadyout_out(hreadyout_out), .hresp_out(hresp_out), .pad_a_out(pad_a_out),
  .pad_a_oe_out(pad_a_oe_out), .pad_b_out(pad_b_out), .pad_b_oe_out(pad_b_oe_out));

//--- sim/tdp_load.sv
`timescale 1ns/100ps
module tdp_load (
  input  wire logic        clk_in,
  input  wire logic        clr_in,
  input  wire logic        pad_a_in,
  input  wire logic        oe_a_in,
  input  wire logic        pad_b_in,
  input  wire logic        oe_b_in,
  output logic [15:0]      hi_a_out,
  output logic [15:0]      hi_b_out
);
  logic pin_a, pin_b;
  // Load pulls a released pin low
  assign pin_a = oe_a_in ? pad_a_in : 1'b0;
  assign pin_b = oe_b_in ? pad_b_in : 1'b0;
  always_ff @(posedge clk_in) begin
    if (clr_in) begin
      hi_a_out <= 16'h0000;
      hi_b_out <= 16'h0000;
    end else begin
      hi_a_out <= hi_a_out + 16'(pin_a);
      hi_b_out <= hi_b_out + 16'(pin_b);
    end
  end
endmodule // tdp_load

//--- sim/timer16_dual_slope_pwm_out_tb.sv
`timescale 1ns/100ps
`include "tdp_map.svh"
module timer16_dual_slope_pwm_out_tb;
  import tdp_pkg::*;
  logic         clk, rst_b, hrdy, hrdy_n, hresp, pd, clr, pa, pb, oe_a, oe_b, e;
  tdp_ahb_req_t req;
  logic [31:0]  wd, hrd, hrd_n, r;
  logic [15:0]  ha, hb;
  logic [1:0]   m, mb;
  logic [1:0]   ms [5] = '{2'h3, 2'h2, 2'h1, 2'h1, 2'h0};
  int           errors, checked, t, c, n;
  tdp_timer dut (.ref_clk_in(clk), .rst_b_in(rst_b), .ahb_req_in(req), .hready_in(hrdy),
    .hwdata_in(wd), .hrdata_out(hrd), .hreadyout_out(hrdy), .hresp_out(hresp),
    .port_data_a_in(pd), .port_data_b_in(pd), .pad_a_out(pa), .pad_a_oe_out(oe_a),
    .pad_b_out(pb), .pad_b_oe_out(oe_b));
  tdp_load u_load (.clk_in(clk), .clr_in(clr), .pad_a_in(pa), .oe_a_in(oe_a),
    .pad_b_in(pb), .oe_b_in(oe_b), .hi_a_out(ha), .hi_b_out(hb));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // Values seen just before each rising edge, free of update races
  always @(negedge clk) begin
    hrdy_n = hrdy;
    hrd_n  = hrd;
  end
  task finish_test;
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    checked++;
    if (got !== ex) begin
      errors++;
      $display("ERROR %s expected %h seen %h", nm, ex, got);
    end
  endtask
  task waitr;
    int i;
    for (i = 0; i < 100; i++) begin
      @(posedge clk);
      if (hrdy_n === 1'b1) break;
    end
    if (i == 100) begin
      errors++;
      finish_test;
    end
  endtask
  task bus(input logic w, input logic [7:0] ad, input logic [31:0] d, output logic [31:0] q);
    req <= '{haddr: {24'h0, ad}, htrans: 2'h2, hwrite: w, hsize: 3'h2, hsel: 1'b1};
    waitr;
    req.htrans <= 2'h0;
    req.hsel   <= 1'b0;
    wd         <= d;
    waitr;
    q = hrd_n;
  endtask
  function automatic int exp_b(logic [1:0] md, int tp, int cp, logic p);
    return (md == 2'h1) ? (p ? 4 * tp : 0) : (md == 2'h2) ? 4 * cp : 4 * (tp - cp);
  endfunction
  initial begin
    rst_b = 1'b0;
    req = '0;
    wd = '0;
    pd = 1'b0;
    clr = 1'b1;
    e = 1'b0;
    errors = 0;
    checked = 0;
    void'($urandom(30));
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    bus(1'b0, `TDP_OFS_CTRL_A, 0, r);
    chk("ctrl_a reset", 0, r);
    bus(1'b1, `TDP_OFS_CTRL_A, 32'hFF, r);
    bus(1'b0, `TDP_OFS_CTRL_A, 0, r);
    chk("ctrl_a readback", 32'hF3, r);
    bus(1'b0, 8'h40, 0, r);
    chk("unmapped read", 0, r);
    bus(1'b1, `TDP_OFS_CTRL_B, 0, r);
    bus(1'b1, `TDP_OFS_PINS, 32'hC, r);
    $display("test registers done");
    foreach (ms[i]) begin
      m = ms[i];
      pd <= 1'($urandom);
      // Settle the modes first so the strobe meets a non-PWM mode and the new output mode
      bus(1'b1, `TDP_OFS_CTRL_A, {24'h0, m, m, 4'h0}, r);
      bus(1'b1, `TDP_OFS_CTRL_A, {24'h0, m, m, 4'hC}, r);
      e = m[1] ? m[0] : (m[0] ? ~e : pd);
      repeat (3) @(posedge clk);
      chk("forced pad a", {31'h0, e}, {31'h0, pa});
      chk("forced pad b", {31'h0, e}, {31'h0, pb});
    end
    chk("pad a enable", 1, {31'h0, oe_a});
    $display("test forced compare done");
    for (int k = 0; k < 4; k++) begin
      t = (k == 0) ? 3 : 4 + $urandom % 37;
      c = (k == 0) ? 0 : (k == 1) ? t : $urandom % t;
      mb = (k == 3) ? 2'h1 : 2'h2 + 2'($urandom % 2);
      n = (k == 2) ? 8 : 1;
      // Stop and rewind first so a smaller TOP cannot be overrun
      bus(1'b1, `TDP_OFS_CTRL_B, 32'h10, r);
      bus(1'b1, `TDP_OFS_COUNT, 0, r);
      bus(1'b1, `TDP_OFS_CMP_A, t, r);
      bus(1'b1, `TDP_OFS_CMP_B, c, r);
      bus(1'b1, `TDP_OFS_FLAGS, 32'h1F, r);
      bus(1'b1, `TDP_OFS_CTRL_A, {24'h0, 2'h1, mb, 4'h1}, r);
      bus(1'b1, `TDP_OFS_CTRL_B, (n == 8) ? 32'h12 : 32'h11, r);
      repeat (8 * t * n + 8) @(posedge clk);
      clr <= 1'b1;
      @(posedge clk);
      clr <= 1'b0;
      repeat (4 * t * n) @(posedge clk);
      #1;
      chk("square wave a", 2 * t * n, {16'h0, ha});
      chk("duty b", exp_b(mb, t, c, pd) * n, {16'h0, hb});
      bus(1'b0, `TDP_OFS_FLAGS, 0, r);
      chk("flags", 7, r & 32'h7);
      $display("test dual slope %0d done", k);
    end
    bus(1'b1, `TDP_OFS_PINS, 32'h4, r);
    @(posedge clk);
    #1;
    chk("pad a driven", 1, {31'h0, oe_a});
    chk("pad b released", 0, {31'h0, oe_b});
    $display("test direction done");
    finish_test;
  end
endmodule // timer16_dual_slope_pwm_out_tb
